// *** verilog/drb_ctl.sv ***
// memory controller end: register port, command timing, read capture
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module drb_ctl #(
	parameter int CK_HALF = drb_pkg::CK_HALF,
	parameter int LAT_ADD = drb_pkg::LAT_ADD_CK,
	parameter int TRP     = drb_pkg::TRP_CK,
	parameter int TRAS    = drb_pkg::TRAS_CK,
	parameter int TRC     = drb_pkg::TRC_CK,
	parameter int TRTP    = drb_pkg::TRTP_CK,
	parameter int COL_GAP = drb_pkg::COL_GAP_CK
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	drb_link_if.ctl          link,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata
);
	localparam int NB = drb_pkg::NB;
	localparam int BW = drb_pkg::BANK_W;
	localparam int RW = drb_pkg::ROW_W;
	localparam int DW = drb_pkg::DQ_W;
	localparam int TW = drb_pkg::TW;

	typedef enum logic {ST_IDLE = 1'b0, ST_PEND = 1'b1} drb_st_t;

	logic [7:0]        div_q;
	logic              ck_q;
	logic              tick_r;
	logic              tick_f;
	drb_st_t           st_q;
	drb_pkg::drb_cmd_t p_cmd_q;
	logic [BW-1:0]     p_bank_q;
	logic [RW-1:0]     p_addr_q;
	drb_pkg::drb_cmd_t cmd_q;
	logic [BW-1:0]     bank_q;
	logic [RW-1:0]     addr_q;
	logic              iss;
	logic              done;
	logic              rd_bad;
	drb_pkg::drb_cmd_t iss_cmd;
	logic [RW-1:0]     iss_addr;
	logic [NB-1:0]     open_q;
	logic [NB-1:0]     pre_ok;
	logic [NB-1:0]     act_ok;
	logic [TW-1:0]     ccd_q;
	logic              wr_cmd;
	logic              wr_stat;
	logic              err_q;
	logic [DW-1:0]     dq_m_q;
	logic [DW-1:0]     dq_s_q;
	logic              dqs_m_q;
	logic              dqs_s_q;
	logic              dqs_d_q;
	logic              beat_ev;
	logic [DW-1:0]     beat_q [8];
	logic [2:0]        idx_q;
	logic [7:0]        cnt_q;
	logic [31:0]       rdata_q;

	// ==========================================
	// link clock divider; commands launch on falls for half a period of setup
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_q <= 8'h0;
			ck_q  <= 1'b0;
		end else if (div_q == 8'(CK_HALF - 1)) begin
			div_q <= 8'h0;
			ck_q  <= ~ck_q;
		end else begin
			div_q <= div_q + 8'h1;
		end
	end
	assign tick_r = div_q == 8'(CK_HALF - 1) && !ck_q;
	assign tick_f = div_q == 8'(CK_HALF - 1) && ck_q;

	assign wr_cmd  = reg_wr && reg_addr == drb_pkg::REG_CMD;
	assign wr_stat = reg_wr && reg_addr == drb_pkg::REG_STAT;

	// ==========================================
	// issue decision for the pending command
	always_comb begin
		iss      = 1'b0;
		done     = 1'b0;
		rd_bad   = 1'b0;
		iss_cmd  = p_cmd_q;
		iss_addr = p_addr_q;
		if (st_q == ST_PEND && tick_f) begin
			case (p_cmd_q)
				drb_pkg::CMD_ACT: begin
					if (open_q[p_bank_q]) begin
						if (pre_ok[p_bank_q]) begin
							iss      = 1'b1;
							iss_cmd  = drb_pkg::CMD_PRE;
							iss_addr = '0;
						end
					end else if (act_ok[p_bank_q]) begin
						iss  = 1'b1;
						done = 1'b1;
					end
				end
				drb_pkg::CMD_PRE: begin
					if (p_addr_q[drb_pkg::A_AP] ? &pre_ok : pre_ok[p_bank_q]) begin
						iss  = 1'b1;
						done = 1'b1;
					end
				end
				drb_pkg::CMD_RD: begin
					if (!open_q[p_bank_q]) begin
						done   = 1'b1;
						rd_bad = 1'b1;
					end else if (ccd_q == '0) begin
						iss  = 1'b1;
						done = 1'b1;
					end
				end
				default: done = 1'b1;
			endcase
		end
	end

	// pending command and link outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q     <= ST_IDLE;
			p_cmd_q  <= drb_pkg::CMD_NOP;
			p_bank_q <= '0;
			p_addr_q <= '0;
			cmd_q    <= drb_pkg::CMD_NOP;
			bank_q   <= '0;
			addr_q   <= '0;
		end else begin
			if (st_q == ST_IDLE && wr_cmd) begin
				st_q     <= ST_PEND;
				p_cmd_q  <= drb_pkg::drb_cmd_t'(reg_wdata[drb_pkg::CF_CMD +: 2]);
				p_bank_q <= reg_wdata[drb_pkg::CF_BANK +: BW];
				p_addr_q <= reg_wdata[drb_pkg::CF_ADDR +: RW];
			end else if (done) begin
				st_q <= ST_IDLE;
			end
			if (tick_f) begin
				cmd_q <= iss ? iss_cmd : drb_pkg::CMD_NOP;
				if (iss) begin
					bank_q <= p_bank_q;
					addr_q <= iss_addr;
				end
			end
		end
	end

	// per-bank timers, loaded at issue and counted on link rises
	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic          hit;
		logic [TW-1:0] act_w_q;
		logic [TW-1:0] ras_w_q;
		logic [TW-1:0] pre_w_q;
		logic [TW-1:0] rtp_w_q;
		assign hit       = iss && p_bank_q == BW'(b);
		assign pre_ok[b] = ras_w_q == '0 && rtp_w_q == '0;
		assign act_ok[b] = pre_w_q == '0 && act_w_q == '0;
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				open_q[b] <= 1'b0;
				act_w_q   <= '0;
				ras_w_q   <= '0;
				pre_w_q   <= '0;
				rtp_w_q   <= '0;
			end else if (iss && iss_cmd == drb_pkg::CMD_PRE
				&& (hit || iss_addr[drb_pkg::A_AP])) begin
				open_q[b] <= 1'b0;
				pre_w_q   <= TW'(TRP);
			end else if (hit && iss_cmd == drb_pkg::CMD_ACT) begin
				open_q[b] <= 1'b1;
				act_w_q   <= TW'(TRC);
				ras_w_q   <= TW'(TRAS);
			end else if (hit && iss_cmd == drb_pkg::CMD_RD) begin
				rtp_w_q <= TW'(LAT_ADD + TRTP);
				if (iss_addr[drb_pkg::A_AP]) begin
					open_q[b] <= 1'b0;
					pre_w_q   <= TW'(LAT_ADD + TRTP + TRP);
				end
			end else if (tick_r) begin
				act_w_q <= act_w_q - TW'(act_w_q != '0);
				ras_w_q <= ras_w_q - TW'(ras_w_q != '0);
				pre_w_q <= pre_w_q - TW'(pre_w_q != '0);
				rtp_w_q <= rtp_w_q - TW'(rtp_w_q != '0);
			end
		end
	end

	// column spacing, shared by all banks
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ccd_q <= '0;
		end else if (iss && iss_cmd == drb_pkg::CMD_RD) begin
			ccd_q <= TW'(COL_GAP);
		end else if (tick_r && ccd_q != '0) begin
			ccd_q <= ccd_q - TW'(1);
		end
	end

	// ==========================================
	// read capture: data and strobe share one synchroniser depth
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dq_m_q  <= '0;
			dq_s_q  <= '0;
			dqs_m_q <= 1'b0;
			dqs_s_q <= 1'b0;
			dqs_d_q <= 1'b0;
		end else begin
			dq_m_q  <= link.dq;
			dq_s_q  <= dq_m_q;
			dqs_m_q <= link.dqs;
			dqs_s_q <= dqs_m_q;
			dqs_d_q <= dqs_s_q;
		end
	end
	assign beat_ev = dqs_s_q ^ dqs_d_q;

	// beat store; a beat in the clearing cycle lands in slot zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			idx_q <= 3'h0;
			cnt_q <= 8'h0;
			for (int i = 0; i < 8; i++) begin
				beat_q[i] <= '0;
			end
		end else if (wr_stat && reg_wdata[drb_pkg::SC_CNT]) begin
			idx_q <= {2'h0, beat_ev};
			cnt_q <= {7'h0, beat_ev};
			if (beat_ev) begin
				beat_q[0] <= dq_s_q;
			end
		end else if (beat_ev) begin
			beat_q[idx_q] <= dq_s_q;
			idx_q         <= idx_q + 3'h1;
			cnt_q         <= cnt_q + 8'(cnt_q != 8'hff);
		end
	end

	// sticky error: busy write or read of an idle bank; set beats clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else begin
			err_q <= (wr_cmd && st_q == ST_PEND) || rd_bad
				|| (err_q && !(wr_stat && reg_wdata[drb_pkg::SC_ERR]));
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b || !reg_rd) begin
			rdata_q <= 32'h0;
		end else if (reg_addr == drb_pkg::REG_CMD) begin
			rdata_q <= {10'h0, p_cmd_q, 1'b0, p_bank_q, 1'b0, p_addr_q};
		end else if (reg_addr == drb_pkg::REG_STAT) begin
			rdata_q <= {8'h0, cnt_q, open_q, 6'h0, err_q, st_q == ST_PEND};
		end else if (reg_addr == drb_pkg::REG_DATA0) begin
			rdata_q <= {beat_q[1], beat_q[0]};
		end else if (reg_addr == drb_pkg::REG_DATA1) begin
			rdata_q <= {beat_q[3], beat_q[2]};
		end else if (reg_addr == drb_pkg::REG_DATA2) begin
			rdata_q <= {beat_q[5], beat_q[4]};
		end else if (reg_addr == drb_pkg::REG_DATA3) begin
			rdata_q <= {beat_q[7], beat_q[6]};
		end else begin
			rdata_q <= 32'h0;
		end
	end

	assign link.ck   = ck_q;
	assign link.cmd  = cmd_q;
	assign link.bank = bank_q;
	assign link.addr = addr_q;
	assign reg_rdata = rdata_q;
endmodule

// *** verilog/drb_pkg.sv ***
// shared constants and types for the dram bank/read link
package drb_pkg;
	// ==========================================
	// link commands and widths
	typedef enum logic [1:0] {
		CMD_NOP = 2'h0,
		CMD_ACT = 2'h1,
		CMD_PRE = 2'h2,
		CMD_RD  = 2'h3
	} drb_cmd_t;
	localparam int NB     = 8;
	localparam int BANK_W = 3;
	localparam int ROW_W  = 15;
	localparam int COL_W  = 10;
	localparam int DQ_W   = 16;
	localparam int TW     = 6;
	localparam int A_AP   = 10;
	localparam int A_BSEL = 12;
	// burst-length field of mode_register_zero
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF  = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam int BEATS_LONG = 8;
	localparam int BEATS_CHOP = 4;
	// ==========================================
	// timing, in link clocks unless named otherwise; CK_HALF counts system clocks
	localparam int CLK_PS     = 8000;
	localparam int CK_HALF    = 4;
	localparam int TCK_PS     = 2 * CK_HALF * CLK_PS;
	localparam int COL_GAP_CK = 4;
	localparam int LAT_ADD_CK = 0;
	localparam int LAT_CAS_CK = 6;
	localparam int TRP_CK     = 9;
	localparam int TRAS_CK    = 15;
	localparam int TRC_CK     = 24;
	localparam int TRTP_MIN   = 4;
	localparam int TRTP_PS    = 7500;
	localparam int TRTP_TCK   = (TRTP_PS + TCK_PS - 1) / TCK_PS;
	localparam int TRTP_CK    = (TRTP_TCK > TRTP_MIN) ? TRTP_TCK : TRTP_MIN;
	// ==========================================
	// controller register map and fields
	localparam logic [7:0] REG_CMD   = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_DATA0 = 8'h08;
	localparam logic [7:0] REG_DATA1 = 8'h0c;
	localparam logic [7:0] REG_DATA2 = 8'h10;
	localparam logic [7:0] REG_DATA3 = 8'h14;
	localparam int CF_ADDR = 0;
	localparam int CF_BANK = 16;
	localparam int CF_CMD  = 20;
	localparam int SF_BUSY = 0;
	localparam int SF_ERR  = 1;
	localparam int SF_OPEN = 8;
	localparam int SF_CNT  = 16;
	localparam int SC_ERR  = 0;
	localparam int SC_CNT  = 1;
endpackage

// *** verilog/drb_link_if.sv ***
// command link between memory controller and dram bank logic
`timescale 1ns/1ps
interface drb_link_if;
	logic                          ck;
	logic [1:0]                    cmd;
	logic [drb_pkg::BANK_W-1:0]    bank;
	logic [drb_pkg::ROW_W-1:0]     addr;
	logic [drb_pkg::DQ_W-1:0]      dq;
	logic                          dqs;
	modport ctl (output ck, cmd, bank, addr, input dq, dqs);
	modport dev (input ck, cmd, bank, addr, output dq, dqs);
endinterface

// *** verilog/drb_dev.sv ***
// dram end: bank state, precharge timing and read bursts
`timescale 1ns/1ps
// ==========================================
// Function
// - activate uses bank and row inputs
// - row stays open until its precharge
// - controller precharges before another row
// - precharge closes one bank or all
// - no activation until row precharge elapsed
// - other banks readable during auto precharge
// - idle bank needs activate before read
// - precharge of idle bank is harmless
// - latest precharge restarts precharge time
// - burst bit low chops four, high eight
// - chopped bursts still need four-clock spacing
// - burst bit never part of column
// - auto precharge independent of burst length
// - mode field 00 eight, 01 on-the-fly
// - read to precharge spacing additive plus rtp
// - rtp at least four clocks and 7.5ns
// - controller honours activate-to-precharge minimum
// - reactivate after precharge and row cycle
// - burst starts additive plus cas latency later
module drb_dev #(
	parameter int LAT_ADD = drb_pkg::LAT_ADD_CK,
	parameter int LAT_CAS = drb_pkg::LAT_CAS_CK,
	parameter int TRP     = drb_pkg::TRP_CK,
	parameter int TRTP    = drb_pkg::TRTP_CK,
	parameter int COL_GAP = drb_pkg::COL_GAP_CK
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	drb_link_if.dev         link,
	input  wire logic [1:0] mode_bl,
	input  wire logic       err_clr,
	output logic [7:0]      bank_open,
	output logic            cmd_err
);
	localparam int NB     = drb_pkg::NB;
	localparam int BW     = drb_pkg::BANK_W;
	localparam int RW     = drb_pkg::ROW_W;
	localparam int DW     = drb_pkg::DQ_W;
	localparam int TW     = drb_pkg::TW;
	localparam int LAT_RD = LAT_ADD + LAT_CAS;
	localparam int PW     = DW + 2;

	// ==========================================
	// link synchronisers
	logic              ck_m_q;
	logic              ck_s_q;
	logic              ck_d_q;
	logic [1:0]        cmd_m_q;
	logic [1:0]        cmd_s_q;
	logic [BW-1:0]     bank_m_q;
	logic [BW-1:0]     bank_s_q;
	logic [RW-1:0]     addr_m_q;
	logic [RW-1:0]     addr_s_q;
	logic              rise;
	logic              fall;
	drb_pkg::drb_cmd_t cmd;

	// ==========================================
	// bank and burst state
	logic [NB-1:0]     open_q;
	logic [RW-1:0]     row_q [NB];
	logic [TW-1:0]     wait_q [NB];
	logic [TW-1:0]     ccd_q;
	logic              act_ok;
	logic              rd_ok;
	logic              pre_cmd;
	logic              bad;
	logic              chop;
	logic [DW-1:0]     base;
	logic [PW-1:0]     pipe_q [LAT_RD];
	logic [PW-1:0]     head;
	logic              start;
	logic [3:0]        left_q;
	logic [2:0]        beat_q;
	logic [DW-1:0]     bbase_q;
	logic [DW-1:0]     dq_q;
	logic              dqs_q;
	logic              err_q;

	// two flops on every link input before any logic looks at it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ck_m_q   <= 1'b0;
			ck_s_q   <= 1'b0;
			ck_d_q   <= 1'b0;
			cmd_m_q  <= 2'h0;
			cmd_s_q  <= 2'h0;
			bank_m_q <= '0;
			bank_s_q <= '0;
			addr_m_q <= '0;
			addr_s_q <= '0;
		end else begin
			ck_m_q   <= link.ck;
			ck_s_q   <= ck_m_q;
			ck_d_q   <= ck_s_q;
			cmd_m_q  <= link.cmd;
			cmd_s_q  <= cmd_m_q;
			bank_m_q <= link.bank;
			bank_s_q <= bank_m_q;
			addr_m_q <= link.addr;
			addr_s_q <= addr_m_q;
		end
	end

	// edges of the link clock; commands change on falls, so rises are safe
	assign rise = ck_s_q & ~ck_d_q;
	assign fall = ~ck_s_q & ck_d_q;
	assign cmd  = drb_pkg::drb_cmd_t'(cmd_s_q);

	// command acceptance at each link rising edge
	assign act_ok  = rise && cmd == drb_pkg::CMD_ACT
		&& !open_q[bank_s_q] && wait_q[bank_s_q] == '0;
	assign rd_ok   = rise && cmd == drb_pkg::CMD_RD
		&& open_q[bank_s_q] && ccd_q == '0;
	assign pre_cmd = rise && cmd == drb_pkg::CMD_PRE;
	assign bad     = rise && ((cmd == drb_pkg::CMD_ACT && !act_ok)
		|| (cmd == drb_pkg::CMD_RD && !rd_ok));

	// per-bank row state and precharge countdown
	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic sel;
		assign sel = bank_s_q == BW'(b);
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				open_q[b] <= 1'b0;
				row_q[b]  <= '0;
				wait_q[b] <= '0;
			end else if (rise) begin
				if (pre_cmd && (addr_s_q[drb_pkg::A_AP] || sel)) begin
					open_q[b] <= 1'b0;
					wait_q[b] <= TW'(TRP - 1);
				end else if (act_ok && sel) begin
					open_q[b] <= 1'b1;
					row_q[b]  <= addr_s_q;
				end else if (rd_ok && sel && addr_s_q[drb_pkg::A_AP]) begin
					open_q[b] <= 1'b0;
					wait_q[b] <= TW'(LAT_ADD + TRTP + TRP - 1);
				end else if (wait_q[b] != '0) begin
					wait_q[b] <= wait_q[b] - TW'(1);
				end
			end
		end
	end

	// column spacing between reads, chopped or not
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ccd_q <= '0;
		end else if (rise) begin
			if (rd_ok) begin
				ccd_q <= TW'(COL_GAP - 1);
			end else if (ccd_q != '0) begin
				ccd_q <= ccd_q - TW'(1);
			end
		end
	end

	// burst length from the mode field and the burst-select bit
	always_comb begin
		case (mode_bl)
			drb_pkg::BL_FIX8: chop = 1'b0;
			drb_pkg::BL_OTF:  chop = ~addr_s_q[drb_pkg::A_BSEL];
			drb_pkg::BL_FIX4: chop = 1'b1;
			default:          chop = 1'b0;
		endcase
	end

	// data pattern: column and bank mixed with the open row
	assign base = {3'h0, addr_s_q[drb_pkg::COL_W-1:0], bank_s_q}
		^ {1'b0, row_q[bank_s_q]};

	// read latency pipe, one stage per link clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < LAT_RD; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (rise) begin
			pipe_q[0] <= {rd_ok, chop, base};
			for (int i = 1; i < LAT_RD; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	assign head  = pipe_q[LAT_RD-1];
	assign start = rise && head[PW-1];

	// burst engine: one beat on every link edge, strobe toggles per beat
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			left_q  <= 4'h0;
			beat_q  <= 3'h0;
			bbase_q <= '0;
			dq_q    <= '0;
			dqs_q   <= 1'b0;
		end else if (start) begin
			left_q  <= head[PW-2] ? 4'(drb_pkg::BEATS_CHOP - 1)
				: 4'(drb_pkg::BEATS_LONG - 1);
			beat_q  <= 3'h1;
			bbase_q <= head[DW-1:0];
			dq_q    <= head[DW-1:0];
			dqs_q   <= 1'b1;
		end else if ((rise || fall) && left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			beat_q <= beat_q + 3'h1;
			dq_q   <= bbase_q ^ {beat_q, 13'h0};
			dqs_q  <= ~dqs_q;
		end
	end

	// refused commands are sticky; a new one beats the clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else begin
			err_q <= bad | (err_q & ~err_clr);
		end
	end

	assign link.dq   = dq_q;
	assign link.dqs  = dqs_q;
	assign bank_open = open_q;
	assign cmd_err   = err_q;
endmodule

// *** tb/drb_link_chk.sv ***
// protocol checker for the dram command link, fed by plain signals
`timescale 1ns/1ps
module drb_link_chk #(
	parameter int LAT_ADD = drb_pkg::LAT_ADD_CK,
	parameter int LAT_CAS = drb_pkg::LAT_CAS_CK,
	parameter int TRP     = drb_pkg::TRP_CK,
	parameter int TRAS    = drb_pkg::TRAS_CK,
	parameter int TRC     = drb_pkg::TRC_CK,
	parameter int TRTP    = drb_pkg::TRTP_CK,
	parameter int COL_GAP = drb_pkg::COL_GAP_CK
) (
	input wire logic                        clk,
	input wire logic                        rst_b,
	input wire logic                        ck,
	input wire logic [1:0]                  cmd,
	input wire logic [drb_pkg::BANK_W-1:0]  bank,
	input wire logic [drb_pkg::ROW_W-1:0]   addr,
	input wire logic [drb_pkg::DQ_W-1:0]    dq,
	input wire logic                        dqs
);
	int         pre_q [8];
	int         act_q [8];
	int         rd_q [8];
	int         rda_q;
	logic [7:0] open_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// helper state
	// link rises since each command, saturating so idle banks never trip
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rda_q <= 999;
		end else if ($rose(ck)) begin
			rda_q <= (cmd == drb_pkg::CMD_RD) ? 0 : rda_q + (rda_q < 999);
		end
		for (int i = 0; i < 8; i++) begin
			if (!rst_b) begin
				pre_q[i] <= 999;
				act_q[i] <= 999;
				rd_q[i]  <= 999;
			end else if ($rose(ck)) begin
				pre_q[i] <= pre_q[i] + (pre_q[i] < 999);
				act_q[i] <= act_q[i] + (act_q[i] < 999);
				rd_q[i]  <= rd_q[i] + (rd_q[i] < 999);
				if (cmd == drb_pkg::CMD_PRE && (addr[10] || bank == i))
					pre_q[i] <= 0;
				if (cmd == drb_pkg::CMD_ACT && bank == i)
					act_q[i] <= 0;
				if (cmd == drb_pkg::CMD_RD && bank == i)
					rd_q[i] <= 0;
				// auto precharge starts its timer behind the read
				if (cmd == drb_pkg::CMD_RD && bank == i && addr[10])
					pre_q[i] <= -(LAT_ADD + TRTP);
			end
		end
	end
	// open rows as the link commands leave them
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			open_q <= 8'h00;
		end else if ($rose(ck)) begin
			if (cmd == drb_pkg::CMD_ACT)
				open_q[bank] <= 1'b1;
			if (cmd == drb_pkg::CMD_RD && addr[10])
				open_q[bank] <= 1'b0;
			if (cmd == drb_pkg::CMD_PRE)
				open_q <= addr[10] ? 8'h00 : open_q & ~(8'h01 << bank);
		end
	end
	// ==========================================
	// properties
	property p_cmd_steady;
		$rose(ck) |=> $stable({cmd, bank, addr})[*3];
	endproperty
	property p_act_closed;
		$rose(ck) && cmd == drb_pkg::CMD_ACT |-> !open_q[bank];
	endproperty
	property p_act_trp;
		$rose(ck) && cmd == drb_pkg::CMD_ACT |-> pre_q[bank] >= TRP - 1;
	endproperty
	property p_act_trc;
		$rose(ck) && cmd == drb_pkg::CMD_ACT |-> act_q[bank] >= TRC - 1;
	endproperty
	property p_pre_tras;
		$rose(ck) && cmd == drb_pkg::CMD_PRE && !addr[10]
			|-> act_q[bank] >= TRAS - 1;
	endproperty
	property p_pre_rtp;
		$rose(ck) && cmd == drb_pkg::CMD_PRE && !addr[10]
			|-> rd_q[bank] >= LAT_ADD + ((TRTP > 4) ? TRTP : 4) - 1;
	endproperty
	property p_rd_open;
		$rose(ck) && cmd == drb_pkg::CMD_RD |-> open_q[bank];
	endproperty
	property p_rd_ccd;
		$rose(ck) && cmd == drb_pkg::CMD_RD |-> rda_q >= COL_GAP - 1;
	endproperty
	property p_rd_lat;
		$rose(ck) && rda_q == LAT_ADD + LAT_CAS - 1
			|-> ##[1:5] $changed(dqs);
	endproperty
	a_cmd_steady: assert property (p_cmd_steady)
		else $error("command moved near a link rise");
	a_act_closed: assert property (p_act_closed)
		else $error("activate to a bank with an open row");
	a_act_trp: assert property (p_act_trp)
		else $error("activate inside precharge time");
	a_act_trc: assert property (p_act_trc)
		else $error("activate inside row cycle time");
	a_pre_tras: assert property (p_pre_tras)
		else $error("precharge before activate minimum");
	a_pre_rtp: assert property (p_pre_rtp)
		else $error("precharge too soon after read");
	a_rd_open: assert property (p_rd_open)
		else $error("read to an idle bank");
	a_rd_ccd: assert property (p_rd_ccd)
		else $error("reads closer than column spacing");
	a_rd_lat: assert property (p_rd_lat)
		else $error("read burst did not start at read latency");
	c_pre_all: cover property ($rose(ck) && cmd == 2'h2 && addr[10]);
	c_rd_chop: cover property ($rose(ck) && cmd == 2'h3 && !addr[12]);
	c_rd_auto: cover property ($rose(ck) && cmd == 2'h3 && addr[10]);
endmodule

// *** tb/tb_top.sv ***
// bench: register-driven controller facing the dram end, plus a bad driver
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        rst_b;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [1:0]  mode_bl;
	logic        err_clr;
	logic [7:0]  bank_open;
	logic [7:0]  open2;
	logic        cmd_err;
	logic        err2;
	logic [31:0] rv;
	logic [14:0] row;
	int          n_errors;
	int          checked;
	drb_link_if link ();
	drb_link_if link2 ();
	drb_ctl drb_ctl_i (.clk(clk), .rst_b(rst_b), .link(link.ctl),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	drb_dev drb_dev_i (.clk(clk), .rst_b(rst_b), .link(link.dev),
		.mode_bl(mode_bl), .err_clr(err_clr), .bank_open(bank_open),
		.cmd_err(cmd_err));
	// second dram end, driven by the bench to break the controller's rules
	drb_dev drb_dev_b_i (.clk(clk), .rst_b(rst_b), .link(link2.dev),
		.mode_bl(mode_bl), .err_clr(err_clr), .bank_open(open2),
		.cmd_err(err2));
	drb_link_chk #(.LAT_ADD(drb_pkg::LAT_ADD_CK),
		.LAT_CAS(drb_pkg::LAT_CAS_CK), .TRP(drb_pkg::TRP_CK),
		.TRAS(drb_pkg::TRAS_CK), .TRC(drb_pkg::TRC_CK),
		.TRTP(drb_pkg::TRTP_CK), .COL_GAP(drb_pkg::COL_GAP_CK))
		drb_link_chk_i (
		.clk(clk), .rst_b(rst_b), .ck(link.ck), .cmd(link.cmd),
		.bank(link.bank), .addr(link.addr), .dq(link.dq), .dqs(link.dqs));
	// ==========================================
	// access tasks
	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// queue one link command, then poll until the controller has sent or refused it
	task automatic op(input logic [1:0] c, input logic [2:0] b,
			input logic [14:0] a);
		wr(drb_pkg::REG_CMD, {10'h0, c, 1'b0, b, 1'b0, a});
		rv = 32'h1;
		for (int i = 0; i < 400 && rv[0]; i++)
			rd(drb_pkg::REG_STAT);
		// a command that never leaves counts as a mismatch
		chk("busy", 32'h0, {31'h0, rv[0]});
	endtask
	task automatic settle(input logic [7:0] e);
		for (int i = 0; i < 40 && bank_open !== e; i++)
			@(posedge clk);
		chk("bank_open", {24'h0, e}, {24'h0, bank_open});
	endtask
	// extra wait lets stray beats of a too long burst land before compare
	task automatic cnt(input int n);
		rv = 32'h0;
		for (int i = 0; i < 200 && rv[23:16] < n; i++)
			rd(drb_pkg::REG_STAT);
		repeat (24) @(posedge clk);
		rd(drb_pkg::REG_STAT);
		chk("beats", n, {24'h0, rv[23:16]});
	endtask
	function automatic logic [15:0] beat(input int i);
		return {3'h0, 10'h2a5, 3'h3} ^ {1'b0, row} ^ {i[2:0], 13'h0};
	endfunction
	// k reads of bank 3, column 2a5, then compare count and beats
	task automatic burst(input logic [1:0] m, input logic bs, input int k,
			input int n);
		@(posedge clk);
		mode_bl <= m;
		wr(drb_pkg::REG_STAT, 32'h2);
		repeat (k) op(drb_pkg::CMD_RD, 3'h3, {2'h0, bs, 12'h2a5});
		cnt(n);
		for (int j = 0; j < n / 2; j++) begin
			rd(drb_pkg::REG_DATA0 + 8'(4 * j));
			chk("data", {beat(2*j % (n/k) + 1), beat(2*j % (n/k))}, rv);
		end
	endtask
	// one link period on the second link; ck stands low between calls
	task automatic t2(input logic [1:0] c, input logic [2:0] b,
			input logic [14:0] a);
		link2.cmd  = c;
		link2.bank = b;
		link2.addr = a;
		#62.5 link2.ck = 1'b1;
		#62.5 link2.ck = 1'b0;
	endtask
	task automatic pulse_clr();
		@(posedge clk) err_clr <= 1'b1;
		@(posedge clk) err_clr <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		finish_test();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, err_clr, reg_addr, reg_wdata} = '0;
		{link2.ck, link2.cmd, link2.bank, link2.addr} = '0;
		mode_bl = 2'h1;
		row = 15'h0abc;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(drb_pkg::REG_STAT);
		chk("stat", 32'h0, rv);
		op(drb_pkg::CMD_ACT, 3'h3, 15'h1234);
		settle(8'h08);
		op(drb_pkg::CMD_ACT, 3'h3, row);
		settle(8'h08);
		burst(2'h1, 1'b1, 1, 8);
		burst(2'h1, 1'b0, 1, 4);
		burst(2'h0, 1'b0, 1, 8);
		burst(2'h2, 1'b1, 1, 4);
		burst(2'h3, 1'b0, 1, 8);
		burst(2'h1, 1'b0, 2, 8);
		chk("cmd_err", 32'h0, {31'h0, cmd_err});
		// auto precharge on bank 3 while bank 5 keeps reading
		op(drb_pkg::CMD_ACT, 3'h5, 15'h0055);
		wr(drb_pkg::REG_STAT, 32'h2);
		op(drb_pkg::CMD_RD, 3'h3, 15'h0400);
		op(drb_pkg::CMD_RD, 3'h5, 15'h0001);
		cnt(8);
		settle(8'h20);
		op(drb_pkg::CMD_ACT, 3'h3, row);
		settle(8'h28);
		op(drb_pkg::CMD_PRE, 3'h3, 15'h0);
		settle(8'h20);
		op(drb_pkg::CMD_PRE, 3'h3, 15'h0);
		// let the precharge reach the dram end before looking
		repeat (16) @(posedge clk);
		chk("cmd_err", 32'h0, {31'h0, cmd_err});
		op(drb_pkg::CMD_PRE, 3'h0, 15'h0400);
		settle(8'h00);
		op(drb_pkg::CMD_RD, 3'h3, 15'h0);
		rd(drb_pkg::REG_STAT);
		chk("stat_err", 32'h2, rv & 32'h3);
		wr(drb_pkg::REG_STAT, 32'h1);
		rd(drb_pkg::REG_STAT);
		chk("stat_err", 32'h0, rv & 32'h3);
		rd(8'h40);
		chk("unmapped", 32'h0, rv);
		// second end: precharge restarted, activation comes too early
		t2(drb_pkg::CMD_ACT, 3'h0, 15'h0);
		repeat (15) t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		t2(drb_pkg::CMD_PRE, 3'h0, 15'h0);
		repeat (4) t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		t2(drb_pkg::CMD_PRE, 3'h0, 15'h0);
		repeat (drb_pkg::TRP_CK - 6) t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		t2(drb_pkg::CMD_ACT, 3'h0, 15'h0);
		t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		chk("err2", 32'h1, {31'h0, err2});
		chk("open2", 32'h0, {24'h0, open2});
		pulse_clr();
		#1; // keep link changes off the clk edge
		repeat (3) t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		t2(drb_pkg::CMD_ACT, 3'h0, 15'h0);
		t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		chk("err2", 32'h0, {31'h0, err2});
		chk("open2", 32'h1, {24'h0, open2});
		t2(drb_pkg::CMD_RD, 3'h4, 15'h0);
		t2(drb_pkg::CMD_NOP, 3'h0, 15'h0);
		chk("err2", 32'h1, {31'h0, err2});
		finish_test();
	end
endmodule
